// *** src/sls_scaler.sv ***
/*
 * Signed linear scaler: binary-to-BCD and BCD-to-binary scaling with
 * offset, slope, rounding, saturation and condition flags.
 * Assumes a sequencer that writes source and parameter words over the
 * register port, then writes the go bit and waits for busy to drop.
 */
`include "sls_defs.svh"

// Notes on behaviour
// RQ1 - Forward: zero delta X raises error
// RQ2 - Forward: non-BCD delta Y raises error
// RQ3 - Equals flag set when result is zero
// RQ4 - Forward: carry flag shows negative result
// RQ5 - Forward: dY/dX times (source minus offset)
// RQ6 - Result rounded to nearest integer
// RQ7 - Forward: saturate at plus/minus 9999
// RQ8 - Forward: BCD magnitude, sign in carry
// RQ9 - Offset and slope may be any sign
// RQ10 - Caller: offset, delta X, delta Y order
// RQ11 - Reverse: (BCD source plus offset) times slope
// RQ12 - Reverse: BCD magnitude, sign from carry
// RQ13 - Reverse: clamp to min and max words
// RQ14 - Reverse: non-BCD source raises error
// RQ15 - Reverse: delta X must be BCD 0001-9999
// RQ16 - Reverse: negative flag is result MSB
// RQ17 - Reverse caller: five parameter words in one area
// RQ18 - Caller sets carry sign before reverse
// RQ19 - Forward caller: three parameter words in one area
// RQ20 - Convert only when execution is requested
// RQ21 - Error leaves result word unchanged
module sls_scaler
    import sls_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [15:0] result_o,
    output logic error_flag_o,
    output logic equals_flag_o,
    output logic carry_flag_o,
    output logic negative_flag_o,
    output logic busy_o,
    output logic done_o
);

    localparam int DW = `SLS_DIV_WIDTH;

    // --------
    // Helper functions
    // --------
    // True when every nibble is a decimal digit
    function automatic logic bcd_valid(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int d = 0; d < 4; d++) begin
            if (w[4*d +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Four BCD digits to binary
    function automatic logic [13:0] bcd_to_bin(input logic [15:0] w);
        return 14'(w[15:12]) * 14'h3E8 + 14'(w[11:8]) * 14'h064 + 14'(w[7:4]) * 14'h00A + 14'(w[3:0]);
    endfunction

    // Binary up to 9999 to four BCD digits, shift-and-add-3
    function automatic logic [15:0] bin_to_bcd(input logic [13:0] b);
        logic [29:0] sh;
        sh = {16'h0000, b};
        for (int i = 0; i < 14; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sh[14+4*d +: 4] > 4'h4) begin
                    sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
                end
            end
            sh = sh << 1;
        end
        return sh[29:14];
    endfunction

    // --------
    // State
    // --------
    sls_state_type state_ff, nxt_state;
    sls_mode_type mode_ff, nxt_mode;
    logic carry_in_ff, nxt_carry_in;
    logic [15:0] source_ff, nxt_source;
    logic [15:0] param_ff [`SLS_PAR_WORDS];
    logic [15:0] nxt_param [`SLS_PAR_WORDS];
    logic [15:0] result_ff, nxt_result;
    logic err_ff, nxt_err;
    logic eq_ff, nxt_eq;
    logic cy_ff, nxt_cy;
    logic neg_ff, nxt_neg;
    logic sign_ff, nxt_sign;
    logic done_ff, nxt_done;
    logic [15:0] rdata_ff, nxt_rdata;

    logic go;
    sls_mode_type op_mode;
    logic op_carry;
    logic op_error;
    logic [15:0] p_off, p_dx, p_dy;
    logic signed [16:0] fwd_diff, rev_src, rev_diff, diff;
    logic [16:0] diff_mag;
    logic [15:0] dx_mag, dy_mag, den_mag;
    logic [32:0] num_mag;
    logic quo_neg;
    logic [DW-1:0] div_dividend, div_divisor, quotient;
    logic div_busy, div_done;
    logic [13:0] fwd_mag;
    logic signed [DW:0] rev_val, rev_max, rev_min, rev_clamped;

    assign p_off = param_ff[`SLS_PAR_OFFSET];
    assign p_dx = param_ff[`SLS_PAR_DELTA_X];
    assign p_dy = param_ff[`SLS_PAR_DELTA_Y];

    // Execution request: go bit written while idle
    assign go = wr_i && addr_i == `SLS_REG_CTRL && wdata_i[`SLS_CTRL_GO_BIT] && state_ff == SLS_IDLE; // RQ20

    // --------
    // Operand preparation, signs and magnitudes kept apart
    // --------
    always_comb begin
        // The go word carries the mode and sign of the conversion it starts
        op_mode = go ? sls_mode_type'(wdata_i[`SLS_CTRL_MODE_BIT]) : mode_ff;
        op_carry = go ? wdata_i[`SLS_CTRL_CARRY_BIT] : carry_in_ff; // RQ12
        fwd_diff = 17'(signed'(source_ff)) - 17'(signed'(p_off)); // RQ5 RQ9
        rev_src = op_carry ? -17'(bcd_to_bin(source_ff)) : 17'(bcd_to_bin(source_ff)); // RQ12
        rev_diff = rev_src + 17'(signed'(p_off)); // RQ11 RQ9
        diff = (op_mode == SLS_MODE_FWD) ? fwd_diff : rev_diff;
        diff_mag = diff[16] ? 17'(-diff) : 17'(diff);
        dx_mag = p_dx[15] ? 16'(-p_dx) : p_dx;
        dy_mag = p_dy[15] ? 16'(-p_dy) : p_dy;
        if (op_mode == SLS_MODE_FWD) begin
            // Delta Y is a BCD magnitude, delta X a signed binary word
            num_mag = 33'(bcd_to_bin(p_dy)) * 33'(diff_mag); // RQ5
            den_mag = dx_mag;
            quo_neg = diff[16] ^ p_dx[15];
            op_error = (p_dx == 16'h0000) || !bcd_valid(p_dy); // RQ1 RQ2
        end else begin
            // Delta X is BCD, delta Y a signed binary word
            num_mag = 33'(dy_mag) * 33'(diff_mag); // RQ11
            den_mag = 16'(bcd_to_bin(p_dx));
            quo_neg = diff[16] ^ p_dy[15];
            op_error = !bcd_valid(source_ff) || !bcd_valid(p_dx) || p_dx == 16'h0000; // RQ14 RQ15
        end
        // Round half away from zero: (2N + D) / 2D
        div_dividend = DW'({num_mag, 1'b0}) + DW'(den_mag); // RQ6
        div_divisor = DW'({den_mag, 1'b0});
    end

    // --------
    // Divider
    // --------
    sls_divider #(
        .WIDTH(DW)
    ) u_divider (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(go && !op_error),
        .dividend_i(div_dividend),
        .divisor_i(div_divisor),
        .busy_o(div_busy),
        .done_o(div_done),
        .quotient_o(quotient)
    );

    // --------
    // Result saturation and clamping
    // --------
    always_comb begin
        fwd_mag = (quotient > DW'(`SLS_BCD_MAX)) ? `SLS_BCD_MAX : quotient[13:0]; // RQ7
        rev_val = sign_ff ? -signed'({1'b0, quotient}) : signed'({1'b0, quotient});
        rev_max = (DW+1)'(signed'(param_ff[`SLS_PAR_MAX]));
        rev_min = (DW+1)'(signed'(param_ff[`SLS_PAR_MIN]));
        if (rev_val > rev_max) begin
            rev_clamped = rev_max; // RQ13
        end else if (rev_val < rev_min) begin
            rev_clamped = rev_min; // RQ13
        end else begin
            rev_clamped = rev_val;
        end
    end

    // --------
    // Register writes, sequencing and flag updates
    // --------
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_carry_in = carry_in_ff;
        nxt_source = source_ff;
        nxt_param = param_ff;
        nxt_result = result_ff;
        nxt_err = err_ff;
        nxt_eq = eq_ff;
        nxt_cy = cy_ff;
        nxt_neg = neg_ff;
        nxt_sign = sign_ff;
        nxt_done = 1'b0;
        // Operand writes are taken only while idle
        if (wr_i && state_ff == SLS_IDLE) begin
            if (addr_i == `SLS_REG_CTRL) begin
                nxt_mode = sls_mode_type'(wdata_i[`SLS_CTRL_MODE_BIT]);
                nxt_carry_in = wdata_i[`SLS_CTRL_CARRY_BIT]; // RQ18
            end else if (addr_i == `SLS_REG_SOURCE) begin
                nxt_source = wdata_i;
            end else if (addr_i >= `SLS_REG_PARAM_BASE && addr_i < `SLS_REG_RESULT) begin
                nxt_param[3'(addr_i - `SLS_REG_PARAM_BASE)] = wdata_i;
            end
        end
        case (state_ff)
            SLS_IDLE: begin
                if (go) begin
                    if (op_error) begin
                        nxt_err = 1'b1; // RQ1 RQ2 RQ14 RQ15 RQ21
                        nxt_done = 1'b1;
                    end else begin
                        nxt_sign = quo_neg;
                        nxt_state = SLS_DIVIDE;
                    end
                end
            end
            SLS_DIVIDE: begin
                if (div_done) begin
                    nxt_err = 1'b0; // RQ1
                    nxt_done = 1'b1;
                    nxt_state = SLS_IDLE;
                    if (mode_ff == SLS_MODE_FWD) begin
                        nxt_result = bin_to_bcd(fwd_mag); // RQ5 RQ8
                        nxt_eq = (fwd_mag == 14'h0000); // RQ3
                        nxt_cy = sign_ff && fwd_mag != 14'h0000; // RQ4 RQ8
                    end else begin
                        nxt_result = rev_clamped[15:0]; // RQ11
                        nxt_eq = (rev_clamped[15:0] == 16'h0000); // RQ3
                        nxt_neg = rev_clamped[15]; // RQ16
                    end
                end
            end
            default: begin
                nxt_state = SLS_IDLE;
            end
        endcase
    end

    // Read data, valid only in the cycle after the read strobe
    always_comb begin
        nxt_rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `SLS_REG_CTRL: begin
                    nxt_rdata[`SLS_CTRL_MODE_BIT] = mode_ff;
                    nxt_rdata[`SLS_CTRL_CARRY_BIT] = carry_in_ff;
                end
                `SLS_REG_SOURCE: begin
                    nxt_rdata = source_ff;
                end
                `SLS_REG_RESULT: begin
                    nxt_rdata = result_ff;
                end
                `SLS_REG_FLAGS: begin
                    nxt_rdata[`SLS_FLAG_ERROR_BIT] = err_ff;
                    nxt_rdata[`SLS_FLAG_EQUALS_BIT] = eq_ff;
                    nxt_rdata[`SLS_FLAG_CARRY_BIT] = cy_ff;
                    nxt_rdata[`SLS_FLAG_NEG_BIT] = neg_ff;
                    nxt_rdata[`SLS_FLAG_BUSY_BIT] = (state_ff != SLS_IDLE);
                end
                default: begin
                    if (addr_i >= `SLS_REG_PARAM_BASE && addr_i < `SLS_REG_RESULT) begin
                        nxt_rdata = param_ff[3'(addr_i - `SLS_REG_PARAM_BASE)];
                    end
                end
            endcase
        end
    end

    // Register all block state
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= SLS_IDLE;
            mode_ff <= SLS_MODE_FWD;
            carry_in_ff <= 1'b0;
            source_ff <= `SLS_WORD_RESET;
            for (int i = 0; i < `SLS_PAR_WORDS; i++) begin
                param_ff[i] <= `SLS_WORD_RESET;
            end
            result_ff <= `SLS_WORD_RESET;
            err_ff <= 1'b0;
            eq_ff <= 1'b0;
            cy_ff <= 1'b0;
            neg_ff <= 1'b0;
            sign_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            carry_in_ff <= nxt_carry_in;
            source_ff <= nxt_source;
            param_ff <= nxt_param;
            result_ff <= nxt_result;
            err_ff <= nxt_err;
            eq_ff <= nxt_eq;
            cy_ff <= nxt_cy;
            neg_ff <= nxt_neg;
            sign_ff <= nxt_sign;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
        end
    end

    // --------
    // Outputs
    // --------
    assign rdata_o = rdata_ff;
    assign result_o = result_ff;
    assign error_flag_o = err_ff;
    assign equals_flag_o = eq_ff;
    assign carry_flag_o = cy_ff;
    assign negative_flag_o = neg_ff;
    assign busy_o = (state_ff != SLS_IDLE) || div_busy;
    assign done_o = done_ff;

endmodule

// *** src/sls_defs.svh ***
/*
 * Register indices, field positions, reset values and limits of the
 * signed linear scaler.
 * Assumes it is included by its bare name from the design files only.
 */
`ifndef SLS_DEFS_SVH
`define SLS_DEFS_SVH

// --------
// Register indices on the word address port
// --------
`define SLS_REG_CTRL 4'h0
`define SLS_REG_SOURCE 4'h1
`define SLS_REG_PARAM_BASE 4'h2
`define SLS_REG_RESULT 4'h7
`define SLS_REG_FLAGS 4'h8

// --------
// Parameter word positions from the parameter block base
// --------
`define SLS_PAR_OFFSET 0
`define SLS_PAR_DELTA_X 1
`define SLS_PAR_DELTA_Y 2
`define SLS_PAR_MAX 3
`define SLS_PAR_MIN 4
`define SLS_PAR_WORDS 5

// --------
// Field positions
// --------
`define SLS_CTRL_MODE_BIT 0
`define SLS_CTRL_CARRY_BIT 1
`define SLS_CTRL_GO_BIT 8
`define SLS_FLAG_ERROR_BIT 0
`define SLS_FLAG_EQUALS_BIT 1
`define SLS_FLAG_CARRY_BIT 2
`define SLS_FLAG_NEG_BIT 3
`define SLS_FLAG_BUSY_BIT 4

// --------
// Reset values and limits
// --------
`define SLS_WORD_RESET 16'h0000
`define SLS_BCD_MAX 14'h270F
`define SLS_DIV_WIDTH 36

`endif

// *** src/sls_pkg.sv ***
/*
 * Types shared by the signed linear scaler files.
 * Assumes nothing of its surroundings.
 */
package sls_pkg;

    // Sequencer states, Gray coded
    typedef enum logic {
        SLS_IDLE = 1'b0,
        SLS_DIVIDE = 1'b1
    } sls_state_type;

    // Conversion direction
    typedef enum logic {
        SLS_MODE_FWD = 1'b0,
        SLS_MODE_REV = 1'b1
    } sls_mode_type;

endpackage

// *** src/sls_divider.sv ***
/*
 * Unsigned restoring divider, one quotient bit per clock.
 * Assumes start_i is only raised while busy_o is low.
 */
module sls_divider
    import sls_pkg::*;
#(
    parameter int WIDTH = 36
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [WIDTH-1:0] dividend_i,
    input wire logic [WIDTH-1:0] divisor_i,
    output logic busy_o,
    output logic done_o,
    output logic [WIDTH-1:0] quotient_o
);

    localparam int CW = $clog2(WIDTH + 1);

    logic [WIDTH:0] rem_ff, nxt_rem;
    logic [WIDTH-1:0] quo_ff, nxt_quo;
    logic [WIDTH-1:0] den_ff, nxt_den;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [WIDTH:0] shifted;

    // ------------------------------------------------------------------
    // Next state: load, then shift and subtract
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rem = rem_ff;
        nxt_quo = quo_ff;
        nxt_den = den_ff;
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        shifted = {rem_ff[WIDTH-1:0], quo_ff[WIDTH-1]};
        if (start_i) begin
            nxt_rem = '0;
            nxt_quo = dividend_i;
            nxt_den = divisor_i;
            nxt_cnt = '0;
            nxt_busy = 1'b1;
        end else if (busy_ff) begin
            if (shifted >= {1'b0, den_ff}) begin
                nxt_rem = shifted - {1'b0, den_ff};
                nxt_quo = {quo_ff[WIDTH-2:0], 1'b1};
            end else begin
                nxt_rem = shifted;
                nxt_quo = {quo_ff[WIDTH-2:0], 1'b0};
            end
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CW'(WIDTH - 1)) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end
    end

    // Register the divider state
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rem_ff <= '0;
            quo_ff <= '0;
            den_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            rem_ff <= nxt_rem;
            quo_ff <= nxt_quo;
            den_ff <= nxt_den;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    assign busy_o = busy_ff;
    assign done_o = done_ff;
    assign quotient_o = quo_ff;

endmodule

// *** testbench/sls_scaler_properties.sv ***
/* Concurrent checks on the ports of the signed linear scaler.
   Assumes one clock, an active-low asynchronous reset and the bind below. */
module sls_scaler_properties
    import sls_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] result_o,
    input wire logic error_flag_o,
    input wire logic equals_flag_o,
    input wire logic carry_flag_o,
    input wire logic negative_flag_o,
    input wire logic busy_o,
    input wire logic done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    sls_mode_type mode_ff;
    sls_mode_type nxt_mode;
    logic go_seen;

    // --------
    // Mode of the conversion in flight
    // --------
    // Go as the scaler takes it
    assign go_seen = wr_i && addr_i == 4'h0 && wdata_i[8] && !busy_o;

    always_comb begin
        nxt_mode = mode_ff;
        if (go_seen) begin
            nxt_mode = sls_mode_type'(wdata_i[0]);
        end
    end

    // Registers the mode
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_ff <= SLS_MODE_FWD;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence run_started;
        go_seen ##1 busy_o;
    endsequence
    sequence ok_done;
        done_o && !error_flag_o;
    endsequence

    a_start_answer: assert property (go_seen |=> busy_o != (done_o && error_flag_o))
        else $error("go not answered");
    a_run_length: assert property (run_started |-> ##37 (done_o && !busy_o))
        else $error("no done on cycle 38");
    a_idle_holds: assert property (!done_o |-> $stable(result_o) && $stable(equals_flag_o)
        && $stable(carry_flag_o) && $stable(negative_flag_o)) else $error("outputs moved without done");
    a_error_keeps: assert property (done_o && error_flag_o |-> $stable(result_o))
        else $error("result changed on error");
    a_equals_zero: assert property (ok_done |-> equals_flag_o == (result_o == 16'h0000))
        else $error("equals flag wrong");
    a_fwd_bcd_digits: assert property (ok_done and mode_ff == SLS_MODE_FWD |-> result_o[3:0] <= 4'h9
        && result_o[7:4] <= 4'h9 && result_o[11:8] <= 4'h9 && result_o[15:12] <= 4'h9)
        else $error("forward result not BCD");
    a_fwd_sign: assert property (ok_done and mode_ff == SLS_MODE_FWD && carry_flag_o |-> result_o != 16'h0000)
        else $error("carry on zero result");
    a_rev_negative: assert property (ok_done and mode_ff == SLS_MODE_REV |-> negative_flag_o == result_o[15])
        else $error("negative flag wrong");
    a_done_single: assert property (done_o && !go_seen |=> !done_o)
        else $error("done too long");
    a_read_slot: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside slot");
endmodule

bind sls_scaler sls_scaler_properties u_props (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .result_o(result_o),
    .error_flag_o(error_flag_o), .equals_flag_o(equals_flag_o), .carry_flag_o(carry_flag_o),
    .negative_flag_o(negative_flag_o), .busy_o(busy_o), .done_o(done_o));

// *** testbench/sls_seq_model.sv ***
/* Instruction sequencer model: bus master that loads operands and starts conversions.
   Assumes the scaler's register port answers a read one cycle after the strobe. */
module sls_seq_model (
    input wire logic core_clk_i,
    input wire logic [15:0] rdata_i,
    output logic [3:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        addr_o = 4'h0;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One-cycle write; released lines show the inverse of the last value
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    // One-cycle read; data taken in the slot after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask

    // Source, parameter block from word 0 upward, then go with mode and sign
    task automatic start(input logic [1:0] c, input logic [15:0] s, input logic [15:0] w [5]);
        bus_wr(4'h1, s);
        for (int k = 0; k < (c[0] ? 5 : 3); k++) begin
            bus_wr(4'(k + 2), w[k]);
        end
        bus_wr(4'h0, {7'h00, 1'b1, 6'h00, c});
    endtask
endmodule

// *** testbench/tb.sv ***
/* Self-checking bench for the signed linear scaler.
   Assumes the sequencer model and the bound checker are compiled with it. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i;
    logic [15:0] wdata_i, rdata_o, result_o;
    logic wr_i, rd_i, error_flag_o, equals_flag_o, carry_flag_o, negative_flag_o, busy_o, done_o;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 54;
    logic [15:0] p [5];
    logic [15:0] exp_res = 16'h0000;
    logic exp_eq = 1'b0, exp_c = 1'b0, exp_n = 1'b0, exp_e = 1'b0;
    // Corners: ctrl, source, offset, delta X, delta Y, max, min
    logic [15:0] cor [16][7] = '{
        '{16'h0, 16'h1770, 16'h0000, 16'h1770, 16'h0300, 16'h0, 16'h0},
        '{16'h0, 16'h0000, 16'h07D0, 16'h1770, 16'h0400, 16'h0, 16'h0},
        '{16'h0, 16'h0005, 16'h0005, 16'h0003, 16'h0007, 16'h0, 16'h0},
        '{16'h0, 16'h7FFF, 16'h8000, 16'h0001, 16'h9999, 16'h0, 16'h0},
        '{16'h0, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h9999, 16'h0, 16'h0},
        '{16'h0, 16'h0001, 16'h0000, 16'h0002, 16'h0001, 16'h0, 16'h0},
        '{16'h0, 16'hFFFF, 16'h0000, 16'h0002, 16'h0001, 16'h0, 16'h0},
        '{16'h0, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0, 16'h0},
        '{16'h0, 16'h0001, 16'h0000, 16'h0002, 16'h00A0, 16'h0, 16'h0},
        '{16'h1, 16'h0200, 16'h0000, 16'h0200, 16'h1770, 16'h7FFF, 16'h8000},
        '{16'h3, 16'h0200, 16'h0000, 16'h0200, 16'h1770, 16'h7FFF, 16'h8000},
        '{16'h1, 16'h9999, 16'h0000, 16'h0001, 16'h7FFF, 16'h1000, 16'h8000},
        '{16'h1, 16'h0100, 16'h0000, 16'h0010, 16'h0001, 16'h0005, 16'h0009},
        '{16'h1, 16'h00A0, 16'h0000, 16'h0001, 16'h0001, 16'h7FFF, 16'h8000},
        '{16'h1, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h7FFF, 16'h8000},
        '{16'h1, 16'h0001, 16'h0000, 16'h00B0, 16'h0001, 16'h7FFF, 16'h8000}};

    // Clock at 200 MHz
    always #2.5 core_clk_i = ~core_clk_i;

    // Cycle count and hang limit
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    sls_seq_model seq (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));
    sls_scaler dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .result_o(result_o), .error_flag_o(error_flag_o),
        .equals_flag_o(equals_flag_o), .carry_flag_o(carry_flag_o), .negative_flag_o(negative_flag_o),
        .busy_o(busy_o), .done_o(done_o));

    // --------
    // Reference arithmetic
    // --------
    function automatic int bcd_val(input logic [15:0] w);
        return w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
    endfunction
    function automatic logic is_bcd(input logic [15:0] w);
        return w[15:12] < 4'hA && w[11:8] < 4'hA && w[7:4] < 4'hA && w[3:0] < 4'hA;
    endfunction
    function automatic logic [15:0] to_bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    // Division rounded half away from zero
    function automatic longint rdiv(input longint n, input longint d);
        longint q;
        q = ((n < 0 ? -n : n) * 2 + (d < 0 ? -d : d)) / ((d < 0 ? -d : d) * 2);
        return ((n < 0) != (d < 0)) ? -q : q;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One conversion with optional refused writes while busy, then all results compared
    task automatic run(input logic [15:0] c, input logic [15:0] s, input logic poke);
        longint q;
        int t0;
        logic [15:0] v;
        exp_e = c[0] ? (!is_bcd(s) || !is_bcd(p[1]) || p[1] == 16'h0000) : (p[1] == 16'h0000 || !is_bcd(p[2]));
        if (!exp_e && c[0]) begin
            q = rdiv(longint'($signed(p[2])) * ((c[1] ? -bcd_val(s) : bcd_val(s)) + $signed(p[0])), bcd_val(p[1]));
            if (q > longint'($signed(p[3]))) q = $signed(p[3]);
            else if (q < longint'($signed(p[4]))) q = $signed(p[4]);
            exp_res = q[15:0];
            exp_n = q[15];
        end else if (!exp_e) begin
            q = rdiv(bcd_val(p[2]) * (longint'($signed(s)) - $signed(p[0])), $signed(p[1]));
            exp_c = q < 0;
            q = (q < 0) ? -q : q;
            exp_res = to_bcd(int'(q > 9999 ? 9999 : q));
        end
        if (!exp_e) exp_eq = exp_res == 16'h0000;
        seq.start(c[1:0], s, p);
        #1;
        t0 = cycles;
        if (poke && !exp_e) begin
            seq.bus_wr(4'h1, ~s);
            seq.bus_wr(4'h0, 16'h0103 ^ c);
            #1;
        end
        while (done_o !== 1'b1 && cycles - t0 < 60) begin
            @(posedge core_clk_i);
            #1;
        end
        check("latency", 16'(cycles - t0), exp_e ? 16'h0000 : 16'h0025);
        check("error", 16'(error_flag_o), 16'(exp_e));
        check("result", result_o, exp_res);
        seq.bus_rd(4'h8, v);
        check("flags", v, {11'h000, 1'b0, exp_n, exp_c, exp_eq, exp_e});
        seq.bus_rd(4'h7, v);
        check("result_reg", v, exp_res);
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        logic [15:0] v;
        logic [15:0] c;
        logic [15:0] s;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        seq.bus_rd(4'h8, v);
        check("flags_reset", v, 16'h0000);
        seq.bus_wr(4'h7, 16'h1234);
        seq.bus_rd(4'h7, v);
        check("result_read_only", v, 16'h0000);
        seq.bus_rd(4'hF, v);
        check("unmapped", v, 16'h0000);
        foreach (cor[i]) begin
            for (int k = 0; k < 5; k++) p[k] = cor[i][k + 2];
            run(cor[i][0], cor[i][1], i[0]);
        end
        repeat (24) begin
            c = 16'($random(seed) & 3);
            if (c[0]) begin
                s = to_bcd(($random(seed) & 32'h7FFF) % 10000);
                p = '{16'($random(seed) % 500), to_bcd(($random(seed) & 32'h7FFF) % 10000),
                    16'($random(seed)), 16'($random(seed) & 32'h7FFF), 16'($random(seed) | 32'h8000)};
            end else begin
                s = 16'($random(seed) % 2000);
                p = '{16'($random(seed) % 1000), 16'($random(seed) % 400),
                    to_bcd(($random(seed) & 32'h7FFF) % 2000), 16'h0000, 16'h0000};
            end
            run(c, s, c[1]);
        end
        conclude();
    end
endmodule
